/* File: logic/rmq_pkg.sv */
// rmq_pkg: shared constants of the registration mark qualifier
package rmq_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_SPACING = 8'h04;
  localparam logic [7:0] OFS_TOLERANCE = 8'h08;
  localparam logic [7:0] OFS_IGNORE = 8'h0c;
  localparam logic [7:0] OFS_CYCLE = 8'h10;
  localparam logic [7:0] OFS_PRESET = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_CAPTURE = 8'h24;
  localparam logic [7:0] OFS_COMP = 8'h28;
  // setting limits in feedback units
  localparam logic [31:0] SETTING_MAX = 32'h2000_0000;
  localparam int SETTING_W = 30;
  localparam int PRESET_SIGN_LSB = 15;
  // setup word: axis number in the low byte
  localparam int AXIS_FIELD_W = 8;
  // status word fields
  localparam int ST_OK = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_GOOD = 2;
  localparam int ST_BAD = 3;
  localparam int ST_EXCEEDED = 4;
  localparam int ST_COUNT_LSB = 16;
  localparam int BADCNT_W = 16;
  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_GOOD = 0;
  localparam int IRQ_BAD = 1;
  localparam int IRQ_EXCEEDED = 2;
  localparam int IRQ_REJECT = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage

/* File: logic/rmq_sync.sv */
// rmq_sync: three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module rmq_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic pinIn,
  output logic level
);
  // all state of the synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } rmq_sync_t;

  rmq_sync_t s_q;
  rmq_sync_t s_d;

  // s1 feeds only s2; level moves once s2 and s3 agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = pinIn;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.lvl = s_q.s3;
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
endmodule // rmq_sync
`default_nettype wire

/* File: logic/rmq_judge.sv */
// rmq_judge: mark distance measurement and good / ignore / exceeded tests
`timescale 1ns/1ps
`default_nettype none
module rmq_judge (
  input wire logic [31:0] refPos,
  input wire logic [31:0] pos,
  input wire logic [29:0] spacing,
  input wire logic [29:0] tol,
  input wire logic [29:0] ignore,
  output logic [31:0] expected_mark_spacing,
  output logic ignored,
  output logic good,
  output logic exceeded
);
  logic [31:0] absDist; // distance magnitude, either direction of travel
  logic [33:0] err; // distance magnitude minus spacing, signed
  logic [33:0] absErr; // error magnitude
  logic [30:0] upper; // spacing plus tolerance
  logic acceptAll; // zero spacing and zero ignore

  // distance from the last recognised mark
  always_comb begin
    expected_mark_spacing = pos - refPos;
    absDist = expected_mark_spacing[31] ? 32'h0 - expected_mark_spacing : expected_mark_spacing;
    err = {2'h0, absDist} - {4'h0, spacing};
    absErr = err[33] ? 34'h0 - err : err;
    upper = {1'b0, spacing} + {1'b0, tol};
    acceptAll = (spacing == 30'h0) && (ignore == 30'h0);
    ignored = absDist < {2'h0, ignore};
    // symmetric band around the spacing
    good = acceptAll || (absErr <= {4'h0, tol});
    exceeded = absDist > {1'b0, upper}; // past spacing plus tolerance
  end
endmodule // rmq_judge
`default_nettype wire

/* File: logic/rmq_qualifier.sv */
// rmq_qualifier: registration mark qualifier with position reload and compensation
`timescale 1ns/1ps
`default_nettype none
module rmq_qualifier #(
  parameter int AXES = 4 // axes with a fast input
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [AXES-1:0] fastInput,
  input wire logic [AXES-1:0][31:0] axisPosition,
  input wire logic [AXES-1:0] axisExists,
  input wire logic [AXES-1:0] refMoveQueued,
  input wire logic [rmq_pkg::ADDR_W-1:0] busAddr,
  input wire logic [rmq_pkg::DATA_W-1:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [rmq_pkg::DATA_W-1:0] busRdata,
  output logic positionLoad,
  output logic [$clog2(AXES)-1:0] positionAxis,
  output logic [31:0] positionValue,
  output logic slaveCompStrobe,
  output logic [31:0] slaveCompValue,
  output logic clearNonMotionRef,
  output logic irq
);
  localparam int AXW = $clog2(AXES);

  // all state of the qualifier
  typedef struct packed {
    logic [31:0] spacingStage; // staged settings, checked on setup
    logic [31:0] tolStage;
    logic [31:0] ignoreStage;
    logic [31:0] cycleStage;
    logic [31:0] presetStage;
    logic [29:0] spacing; // active settings
    logic [29:0] tol;
    logic [29:0] ignore;
    logic [29:0] cycle;
    logic [31:0] preset;
    logic [AXW-1:0] axis;
    logic setupOk; // last setup accepted
    logic armed; // some setup accepted since reset
    logic levelPrev; // edge detector on selected level
    logic haveRef; // a reference mark exists
    logic [31:0] refPos;
    logic [31:0] capture;
    logic lastGood;
    logic lastBad;
    logic exceeded;
    logic [rmq_pkg::BADCNT_W-1:0] badCount;
    logic load;
    logic [31:0] loadValue;
    logic comp;
    logic [31:0] compValue;
    logic clearRef;
    logic [rmq_pkg::IRQ_W-1:0] irqStatus;
    logic [rmq_pkg::IRQ_W-1:0] irqMask;
    logic [rmq_pkg::DATA_W-1:0] rdata;
  } rmq_state_t;

  rmq_state_t s_q;
  rmq_state_t s_d;

  logic [AXES-1:0] level; // filtered fast inputs
  logic [31:0] selPos; // feedback of the active axis
  logic markEdge; // rising mark on the active axis
  logic enabled; // registration running
  logic [31:0] expected_mark_spacing;
  logic ignored;
  logic good;
  logic exceeded;
  localparam int AXIS_SEL_W = rmq_pkg::AXIS_FIELD_W;
  localparam int SETTING_W_L = rmq_pkg::SETTING_W; // width of an active setting
  logic [AXIS_SEL_W-1:0] reqAxisField; // axis number in a setup write
  logic reqAxisOk;
  logic rangeOk;
  logic setupWrite;
  logic setupAccept;
  logic [AXW-1:0] reqAxis;

  // one synchroniser per fast input pin
  for (genvar g = 0; g < AXES; g++) begin : gSync
    rmq_sync uSync (
      .clock(clock),
      .reset(reset),
      .pinIn(fastInput[g]),
      .level(level[g])
    );
  end

  // qualification against the last recognised mark
  rmq_judge uJudge (
    .refPos(s_q.refPos),
    .pos(selPos),
    .spacing(s_q.spacing),
    .tol(s_q.tol),
    .ignore(s_q.ignore),
    .expected_mark_spacing(expected_mark_spacing),
    .ignored(ignored),
    .good(good),
    .exceeded(exceeded)
  );

  // setup checks and event detection
  always_comb begin
    selPos = axisPosition[s_q.axis];
    enabled = s_q.armed && (s_q.cycle != 30'h0);
    markEdge = enabled && level[s_q.axis] && !s_q.levelPrev;
    setupWrite = busWrite && (busAddr == rmq_pkg::OFS_SETUP);
    reqAxisField = busWdata[AXIS_SEL_W-1:0];
    reqAxis = reqAxisField[AXW-1:0];
    // axis must exist and have no reference queued active or next
    reqAxisOk = (reqAxisField < AXIS_SEL_W'(AXES)) && axisExists[reqAxis]
                && !refMoveQueued[reqAxis];
    // every setting within limit, preset within signed 16-bit span
    rangeOk = (s_q.spacingStage <= rmq_pkg::SETTING_MAX)
              && (s_q.tolStage <= rmq_pkg::SETTING_MAX)
              && (s_q.ignoreStage <= rmq_pkg::SETTING_MAX)
              && (s_q.cycleStage <= rmq_pkg::SETTING_MAX)
              && ((&s_q.presetStage[31:rmq_pkg::PRESET_SIGN_LSB])
                  || !(|s_q.presetStage[31:rmq_pkg::PRESET_SIGN_LSB]));
    setupAccept = setupWrite && reqAxisOk && rangeOk;
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    s_d.comp = 1'b0;
    s_d.clearRef = 1'b0;
    s_d.rdata = '0;
    s_d.levelPrev = level[s_q.axis];
    // staged settings writes
    if (busWrite) begin
      case (busAddr)
        rmq_pkg::OFS_SPACING: s_d.spacingStage = busWdata;
        rmq_pkg::OFS_TOLERANCE: s_d.tolStage = busWdata;
        rmq_pkg::OFS_IGNORE: s_d.ignoreStage = busWdata;
        rmq_pkg::OFS_CYCLE: s_d.cycleStage = busWdata;
        rmq_pkg::OFS_PRESET: s_d.presetStage = busWdata;
        rmq_pkg::OFS_IRQ_MASK: s_d.irqMask = busWdata[rmq_pkg::IRQ_W-1:0];
        default: s_d.rdata = '0; // unmapped or read-only: ignored
      endcase
    end
    // reads: data stands in the next cycle
    if (busRead) begin
      case (busAddr)
        rmq_pkg::OFS_SETUP: s_d.rdata = 32'(s_q.axis);
        rmq_pkg::OFS_SPACING: s_d.rdata = s_q.spacingStage;
        rmq_pkg::OFS_TOLERANCE: s_d.rdata = s_q.tolStage;
        rmq_pkg::OFS_IGNORE: s_d.rdata = s_q.ignoreStage;
        rmq_pkg::OFS_CYCLE: s_d.rdata = s_q.cycleStage;
        rmq_pkg::OFS_PRESET: s_d.rdata = s_q.presetStage;
        rmq_pkg::OFS_STATUS: begin
          s_d.rdata[rmq_pkg::ST_OK] = s_q.setupOk;
          s_d.rdata[rmq_pkg::ST_ARMED] = enabled;
          s_d.rdata[rmq_pkg::ST_GOOD] = s_q.lastGood;
          s_d.rdata[rmq_pkg::ST_BAD] = s_q.lastBad;
          s_d.rdata[rmq_pkg::ST_EXCEEDED] = s_q.exceeded;
          s_d.rdata[rmq_pkg::ST_COUNT_LSB +: rmq_pkg::BADCNT_W] = s_q.badCount;
        end
        rmq_pkg::OFS_IRQ_STATUS: begin
          s_d.rdata = 32'(s_q.irqStatus);
          s_d.irqStatus = rmq_pkg::IRQ_RESET; // read clears, sets below win
        end
        rmq_pkg::OFS_IRQ_MASK: s_d.rdata = 32'(s_q.irqMask);
        rmq_pkg::OFS_CAPTURE: s_d.rdata = s_q.capture;
        rmq_pkg::OFS_COMP: s_d.rdata = s_q.compValue;
        default: s_d.rdata = '0; // unmapped reads as zero
      endcase
    end
    if (setupWrite) begin
      // setup takes precedence over a mark in the same cycle
      s_d.setupOk = setupAccept;
      if (setupAccept) begin
        s_d.spacing = s_q.spacingStage[SETTING_W_L-1:0];
        s_d.tol = s_q.tolStage[SETTING_W_L-1:0];
        s_d.ignore = s_q.ignoreStage[SETTING_W_L-1:0];
        s_d.cycle = s_q.cycleStage[SETTING_W_L-1:0];
        s_d.preset = s_q.presetStage;
        s_d.axis = reqAxis;
        s_d.armed = 1'b1;
        s_d.haveRef = 1'b0; // restart the mark chain
        s_d.levelPrev = level[reqAxis]; // no false edge on axis change
        s_d.clearRef = 1'b1;
      end else begin
        s_d.irqStatus[rmq_pkg::IRQ_REJECT] = 1'b1;
      end
    end else if (markEdge) begin
      s_d.capture = selPos;
      if (!s_q.haveRef || (!ignored && good)) begin
        // good mark: reload position, reference moves to preset frame
        s_d.haveRef = 1'b1;
        s_d.load = 1'b1;
        s_d.loadValue = s_q.preset;
        s_d.refPos = s_q.preset;
        s_d.lastGood = 1'b1;
        s_d.lastBad = 1'b0;
        s_d.exceeded = s_q.haveRef && exceeded;
        s_d.badCount = '0;
        s_d.irqStatus[rmq_pkg::IRQ_GOOD] = 1'b1;
        if (s_q.haveRef) begin
          // error against cycle length goes to the slave only
          s_d.comp = 1'b1;
          s_d.compValue = expected_mark_spacing - {2'h0, s_q.cycle};
        end
      end else if (!ignored) begin
        // recognised but bad: still the new reference
        s_d.refPos = selPos;
        s_d.lastGood = 1'b0;
        s_d.lastBad = 1'b1;
        s_d.exceeded = exceeded;
        if (s_q.badCount != '1) begin
          s_d.badCount = s_q.badCount + 1'b1;
        end
        s_d.irqStatus[rmq_pkg::IRQ_BAD] = 1'b1;
        if (exceeded) begin
          s_d.irqStatus[rmq_pkg::IRQ_EXCEEDED] = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state
  assign busRdata = s_q.rdata;
  assign positionLoad = s_q.load;
  assign positionAxis = s_q.axis;
  assign positionValue = s_q.loadValue;
  assign slaveCompStrobe = s_q.comp;
  assign slaveCompValue = s_q.compValue;
  assign clearNonMotionRef = s_q.clearRef;
  assign irq = |(s_q.irqStatus & s_q.irqMask);

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_mark_seen;
    markEdge && !setupWrite;
  endsequence
  sequence s_bad_mark;
    s_mark_seen ##0 (s_q.haveRef && !ignored && !good);
  endsequence

  a_capture_pos: assert property (
    s_mark_seen |=> s_q.capture == $past(selPos))
    else $error("capture does not hold feedback at mark");
  a_good_loads: assert property (
    s_mark_seen ##0 (!ignored && good) |=> positionLoad && positionValue == $past(s_q.preset))
    else $error("good mark did not load preset");
  a_band_reject: assert property (
    s_mark_seen ##0 (s_q.haveRef && !ignored && !good) |=> !positionLoad)
    else $error("mark outside band loaded position");
  a_ignore_quiet: assert property (
    s_mark_seen ##0 (s_q.haveRef && ignored) |=> !positionLoad && $stable(s_q.refPos)
      && $stable(s_q.badCount))
    else $error("ignored mark changed state");
  a_bad_reference: assert property (
    s_bad_mark |=> s_q.refPos == $past(selPos))
    else $error("bad mark did not become reference");
  a_accept_all: assert property (
    s_mark_seen ##0 (s_q.spacing == 30'h0 && s_q.ignore == 30'h0) |=> positionLoad)
    else $error("accept-all mode missed a mark");
  a_zero_cycle: assert property (
    (s_q.cycle == 30'h0) |=> !positionLoad ##1 !positionLoad)
    else $error("load while registration is off");
  a_reject_setup: assert property (
    setupWrite && !reqAxisOk |=> !s_q.setupOk && !clearNonMotionRef)
    else $error("setup accepted for bad axis");
  a_clear_ref: assert property (
    setupAccept ##1 !setupAccept |-> clearNonMotionRef ##1 !clearNonMotionRef)
    else $error("accepted setup did not clear reference");
  a_bad_count: assert property (
    s_bad_mark ##0 (s_q.badCount != '1) |=> s_q.badCount == $past(s_q.badCount) + 1'b1
      && s_q.lastBad)
    else $error("bad count not advanced");
  a_comp_value: assert property (
    s_mark_seen ##0 (s_q.haveRef && !ignored && good) |=> slaveCompStrobe
      && slaveCompValue == $past(expected_mark_spacing) - {2'h0, $past(s_q.cycle)})
    else $error("compensation value wrong");
endmodule // rmq_qualifier
`default_nettype wire

/* File: test/rmq_eye.sv */
// rmq_eye: behavioural photo eye driving one fast input pin
`timescale 1ns/1ps
`default_nettype none
module rmq_eye #(
  parameter int WIDTH = 8 // clocks the pin stays high per mark
) (
  input wire logic clock,
  input wire logic fire,
  output logic pin
);
  int left; // clocks of the current pulse still to go
  initial begin
    pin = 1'b0;
    left = 0;
  end
  // output lags the clock edge by a fixed 37 ns so the pin never changes on a sampling edge
  always @(posedge clock) begin
    if (fire) begin
      left = WIDTH;
    end else if (left > 0) begin
      left = left - 1;
    end
    pin <= #37 (left > 0);
  end
endmodule // rmq_eye
`default_nettype wire

/* File: test/rmq_qualifier_test.sv */
// rmq_qualifier_test: self-checking bench of the registration mark qualifier
`timescale 1ns/1ps
`default_nettype none
module rmq_qualifier_test;
  typedef struct {
    logic [31:0] pos; // feedback position at the mark
    logic load; // reload expected
    logic str; // compensation strobe expected
    logic [31:0] comp; // compensation value
    logic [2:0] sts; // exceeded, bad, good
    logic [15:0] cnt; // consecutive bad marks
  } rmq_row_t;
  logic clock, reset, busWrite, busRead, positionLoad, slaveCompStrobe, clearNonMotionRef, irq;
  wire logic [3:0] fastInput; // driven bit by bit by the eyes
  logic [3:0] fire, axisExists, refMoveQueued;
  logic [3:0][31:0] axisPosition;
  logic [7:0] busAddr;
  logic [31:0] busWdata, busRdata, positionValue, slaveCompValue, rdv, gotVal, gotComp;
  logic [1:0] positionAxis, gotAxis;
  logic sawLoad, sawComp, ok;
  int miscompares, checkCount;
  // setup: axis 1, spacing 1000, tolerance 10, ignore 200, cycle 1000, preset 5
  rmq_row_t rows [11] = '{
    '{32'h309, 1, 0, 32'h0, 3'h1, 16'h0}, // first mark taken good
    '{32'h3ed, 1, 1, 32'h0, 3'h1, 16'h0}, // exact spacing
    '{32'h3f7, 1, 1, 32'ha, 3'h1, 16'h0}, // top of band
    '{32'h3f8, 0, 0, 32'h0, 3'h6, 16'h1}, // one past band
    '{32'h45c, 0, 0, 32'h0, 3'h6, 16'h1}, // inside ignore window
    '{32'h7d6, 1, 1, 32'hfffffff6, 3'h1, 16'h0}, // bottom of band from bad ref
    '{32'h3e2, 0, 0, 32'h0, 3'h2, 16'h1}, // short, not exceeded
    '{32'h5d6, 0, 0, 32'h0, 3'h2, 16'h2},
    '{32'h69e, 0, 0, 32'h0, 3'h2, 16'h3}, // exactly at ignore edge
    '{32'h765, 0, 0, 32'h0, 3'h2, 16'h3}, // one short of ignore edge
    '{32'ha86, 1, 1, 32'h0, 3'h1, 16'h0}};
  // one photo eye per axis
  for (genvar i = 0; i < 4; i++) begin : g_eye
    rmq_eye #(.WIDTH(8)) eye (.clock(clock), .fire(fire[i]), .pin(fastInput[i]));
  end
  rmq_qualifier #(.AXES(4)) uut (.clock(clock), .reset(reset), .fastInput(fastInput),
    .axisPosition(axisPosition), .axisExists(axisExists), .refMoveQueued(refMoveQueued),
    .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
    .busRdata(busRdata), .positionLoad(positionLoad), .positionAxis(positionAxis),
    .positionValue(positionValue), .slaveCompStrobe(slaveCompStrobe),
    .slaveCompValue(slaveCompValue), .clearNonMotionRef(clearNonMotionRef), .irq(irq));
  // free running system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // second edge keeps a strobe from being raised and dropped in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAddr <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge clock);
    busWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clock);
    busRead <= 0;
    #1 d = busRdata;
    @(posedge clock);
  endtask
  // stage all settings, apply them, watch for the reference clear pulse
  task automatic setup(input logic [7:0] ax, input logic [31:0] sp, tl, ig, cy, pr);
    wr(rmq_pkg::OFS_SPACING, sp);
    wr(rmq_pkg::OFS_TOLERANCE, tl);
    wr(rmq_pkg::OFS_IGNORE, ig);
    wr(rmq_pkg::OFS_CYCLE, cy);
    wr(rmq_pkg::OFS_PRESET, pr);
    busAddr <= rmq_pkg::OFS_SETUP;
    busWdata <= {24'h0, ax};
    busWrite <= 1'b1;
    ok = 0;
    repeat (4) begin
      @(posedge clock);
      busWrite <= 1'b0;
      #1 ok = ok | (clearNonMotionRef === 1'b1);
    end
    @(posedge clock);
  endtask
  // present a position, flash the eye, record what the block answers
  task automatic mark(input int ax, input logic [31:0] pos);
    axisPosition[ax] <= pos;
    fire[ax] <= 1'b1;
    @(posedge clock);
    fire[ax] <= 1'b0;
    sawLoad = 0;
    sawComp = 0;
    repeat (20) begin
      @(posedge clock);
      #1;
      if (positionLoad === 1'b1) begin
        sawLoad = 1;
        gotAxis = positionAxis;
        gotVal = positionValue;
      end
      if (slaveCompStrobe === 1'b1) begin
        sawComp = 1;
        gotComp = slaveCompValue;
      end
    end
    @(posedge clock);
  endtask
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: whole run needs well under 5000 clocks
  initial begin
    #2_000_000;
    miscompares++;
    tallyAndFinish;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    {fire, busWrite, busRead, busAddr, busWdata} = '0;
    axisPosition = '0;
    axisExists = 4'hf;
    refMoveQueued = 4'h0;
    repeat (16) @(posedge clock);
    #1 chk({irq, positionLoad, busRdata}, 33'h0, "outputs in reset");
    @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(rmq_pkg::OFS_STATUS, rdv);
    chk(rdv, 32'h0, "status after reset");
    rd(8'h3c, rdv);
    chk(rdv, 32'h0, "unmapped read");
    wr(rmq_pkg::OFS_IRQ_MASK, 32'hf);
    setup(8'h1, 32'h3e8, 32'ha, 32'hc8, 32'h3e8, 32'h5);
    chk(ok, 1, "reference clear on accept");
    // ordinary marks from the table
    foreach (rows[i]) begin
      mark(1, rows[i].pos);
      chk(sawLoad, rows[i].load, "reload");
      if (rows[i].load) chk({gotAxis, gotVal}, {2'h1, 32'h5}, "preset");
      chk(sawComp, rows[i].str, "comp strobe");
      if (rows[i].str) chk(gotComp, rows[i].comp, "comp value");
      rd(rmq_pkg::OFS_CAPTURE, rdv);
      chk(rdv, rows[i].pos, "capture");
      rd(rmq_pkg::OFS_STATUS, rdv);
      chk({rdv[31:16], rdv[4:0]}, {rows[i].cnt, rows[i].sts, 2'h3}, "status");
    end
    // interrupt: raised, cleared by read, masked
    chk(irq, 1, "irq set");
    rd(rmq_pkg::OFS_IRQ_STATUS, rdv);
    chk(rdv, 32'h7, "irq status");
    chk(irq, 0, "irq cleared by read");
    wr(rmq_pkg::OFS_IRQ_MASK, 32'h0);
    mark(1, 32'h3ed);
    chk(irq, 0, "irq masked");
    wr(rmq_pkg::OFS_IRQ_MASK, 32'h1);
    chk(irq, 1, "irq unmasked");
    rd(rmq_pkg::OFS_IRQ_STATUS, rdv);
    chk(rdv, 32'h1, "irq good only");
    // mark on an axis not configured
    mark(0, 32'h3ed);
    chk(sawLoad, 0, "other axis");
    // refused setups leave the running one alone
    axisExists <= 4'hb;
    refMoveQueued <= 4'h8;
    for (int k = 0; k < 5; k++) begin
      setup(k < 3 ? 8'(k + 2) : 8'h1, k == 3 ? 32'h2000_0001 : 32'h3e8, 32'ha, 32'hc8,
            32'h3e8, k == 4 ? 32'h8000 : 32'h5);
      chk(ok, 0, "no clear on reject");
      rd(rmq_pkg::OFS_STATUS, rdv);
      chk(rdv[0], 0, "setup refused");
      rd(rmq_pkg::OFS_IRQ_STATUS, rdv);
      chk(rdv[3], 1, "reject irq");
    end
    mark(1, 32'h3ed);
    chk(sawLoad, 1, "old setup runs");
    // largest spacing and lowest preset are legal
    setup(8'h1, 32'h2000_0000, 32'h0, 32'h0, 32'h3e8, 32'hffff8000);
    chk(ok, 1, "limits accepted");
    mark(1, 32'h64);
    chk({sawLoad, gotVal}, {1'b1, 32'hffff8000}, "negative preset");
    // zero spacing and ignore accept everything, even close marks
    setup(8'h1, 32'h0, 32'h0, 32'h0, 32'h3e8, 32'h7);
    mark(1, 32'h32);
    chk(sawLoad, 1, "accept all first");
    mark(1, 32'h8);
    chk(sawLoad, 1, "accept all close");
    // zero cycle length stops registration
    setup(8'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7);
    mark(1, 32'h40);
    chk(sawLoad, 0, "cycle zero off");
    rd(rmq_pkg::OFS_STATUS, rdv);
    chk(rdv[1], 0, "not running");
    tallyAndFinish;
  end
endmodule // rmq_qualifier_test
`default_nettype wire
